// file: mac_stats_map.vh
// Purpose: Attribute identifiers, field positions, reset values and encodings for the MAC attribute bank
// Assumes: Identifiers are the attribute ids passed with a get or list-get request
// Notes: Definitions only
`ifndef MAC_STATS_MAP_VH
`define MAC_STATS_MAP_VH

`define ID_FRAME_GUARD_TIME 16'h002F
`define ID_BACKWARD_COMPAT_FLAG 16'h0030
`define ID_PARENT_BEACON_QUALITY 16'h0032
`define ID_OWN_BEACON_QUALITY 16'h0033
`define ID_TX_DATA_UNIT_COUNT 16'h0040
`define ID_RX_DATA_UNIT_COUNT 16'h0041
`define ID_TX_CONTROL_COUNT 16'h0042
`define ID_RX_CONTROL_COUNT 16'h0043
`define ID_POWERLINE_ACCESS_FAIL_COUNT 16'h0044
`define ID_POWERLINE_BUSY_BACKOFF_COUNT 16'h0045
`define ID_RADIO_ACCESS_FAIL_COUNT 16'h0046
`define ID_RADIO_BUSY_BACKOFF_COUNT 16'h0047
`define ID_REGISTERED_NODE_LIST 16'h0050
`define ID_ACTIVE_CONNECTION_LIST 16'h0051

`define GUARD_TIME_SYMBOLS 16'h0001
`define COUNT_RESET 32'h0000_0000
`define NUM_COUNTERS 8
`define COUNTER_ID_BASE 16'h0040

`define STATE_TERMINAL 8'h01
`define STATE_SWITCH 8'h02

`define SWCAP_VALID_MASK 8'h09

// Registered-node entry word layout (three 32-bit words per entry)
`define REG_W0_ID_LO 0
`define REG_W1_ID_HI 1
`define REG_W2_MISC 2
`define REG_WORDS 3
// Connection entry word layout (two words per entry)
`define CONN_WORDS 2

`endif

// file: mac_statistics_attribute_bank.v
// Purpose: Read-only MAC attribute bank with statistics counters and base-node lists
// Assumes: Event inputs are one-cycle pulses from MAC logic on i_clk_sys; list contents are
//          written by the MAC's own engine, never by the management port
// Notes: Get answers one cycle after the request; list-get answers one word per request
//        Counters and list valid bits clear on reset; entry words do not, invalid slots read
//        as zero instead, which keeps the entry memories free of reset logic
`timescale 1ns/1ns
`include "mac_stats_map.vh"

module mac_statistics_attribute_bank #(
  parameter REG_ENTRIES = 16,
  parameter REG_IDX_W = 4,
  parameter CONN_ENTRIES = 16,
  parameter CONN_IDX_W = 4
) (
  input wire i_clk_sys,
  input wire i_reset,
  // Device role and live attribute sources
  input wire i_base_node,
  input wire i_backward_compat_mode,
  input wire [15:0] i_parent_beacon_quality,
  input wire i_parent_beacon_valid,
  input wire [15:0] i_own_beacon_quality,
  input wire i_own_beacon_valid,
  // Statistics events
  input wire i_tx_data_ok,
  input wire i_rx_data_ok,
  input wire i_rx_data_for_me,
  input wire i_tx_ctrl_ok,
  input wire i_rx_ctrl_ok,
  input wire i_rx_ctrl_for_me,
  input wire i_powerline_access_fail,
  input wire i_powerline_busy_backoff,
  input wire i_radio_access_fail,
  input wire i_radio_busy_backoff,
  // MAC-side registered-node list update
  input wire i_reg_wr,
  input wire [REG_IDX_W-1:0] i_reg_idx,
  input wire i_reg_valid,
  input wire [47:0] i_reg_node_id,
  input wire [15:0] i_reg_local_node_id,
  input wire [7:0] i_reg_state,
  input wire [7:0] i_reg_local_switch_id,
  input wire [7:0] i_reg_switch_id,
  input wire [7:0] i_reg_level,
  input wire [7:0] i_reg_term_cap,
  input wire [7:0] i_reg_sw_cap,
  // MAC-side active connection list update
  input wire i_conn_wr,
  input wire [CONN_IDX_W-1:0] i_conn_idx,
  input wire i_conn_valid,
  input wire i_conn_direct,
  input wire [7:0] i_conn_switch_id,
  input wire [15:0] i_conn_local_node_id,
  input wire [15:0] i_conn_local_conn_id,
  input wire [47:0] i_conn_node_id,
  // Management get primitive
  input wire i_get_req,
  input wire [15:0] i_get_id,
  output reg o_get_ack,
  output reg o_get_ok,
  output reg [31:0] o_get_data,
  // Management list-get primitive
  input wire i_list_req,
  input wire [15:0] i_list_id,
  input wire [7:0] i_list_entry,
  input wire [1:0] i_list_word,
  output reg o_list_ack,
  output reg o_list_ok,
  output reg o_list_entry_valid,
  output reg [31:0] o_list_data
);

  // Counter slot order follows the identifier order 0x40..0x47
  wire [`NUM_COUNTERS-1:0] count_event;
  assign count_event[0] = i_tx_data_ok;
  assign count_event[1] = i_rx_data_ok & i_rx_data_for_me;
  assign count_event[2] = i_tx_ctrl_ok;
  assign count_event[3] = i_rx_ctrl_ok & i_rx_ctrl_for_me;
  assign count_event[4] = i_powerline_access_fail;
  assign count_event[5] = i_powerline_busy_backoff;
  assign count_event[6] = i_radio_access_fail;
  assign count_event[7] = i_radio_busy_backoff;

  // Each counter lives in its own generate scope so every register has one driver
  wire [31:0] counter_w [0:`NUM_COUNTERS-1];
  genvar g;
  generate
    for (g = 0; g < `NUM_COUNTERS; g = g + 1) begin : g_cnt
      reg [31:0] count_r;
      always @(posedge i_clk_sys) begin
        if (i_reset) begin
          count_r <= `COUNT_RESET;
        end else if (count_event[g]) begin
          // Natural 32-bit wrap; no saturation so deltas stay valid across overflow
          count_r <= count_r + 32'h0000_0001;
        end
      end
      assign counter_w[g] = count_r;
    end
  endgenerate

  reg bc_mode_r;
  reg [15:0] parent_quality_r;
  reg [15:0] own_quality_r;
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      bc_mode_r <= 1'b0;
      parent_quality_r <= 16'h0000;
      own_quality_r <= 16'h0000;
    end else begin
      bc_mode_r <= i_backward_compat_mode;
      if (i_parent_beacon_valid) begin
        parent_quality_r <= i_parent_beacon_quality;
      end
      if (i_own_beacon_valid) begin
        own_quality_r <= i_own_beacon_quality;
      end
    end
  end

  // List storage: written only from the MAC side, the management port has no path here
  reg [31:0] reg_mem [0:REG_ENTRIES*`REG_WORDS-1];
  reg [REG_ENTRIES-1:0] reg_valid_r;
  reg [31:0] conn_mem [0:CONN_ENTRIES*`CONN_WORDS-1];
  reg [CONN_ENTRIES-1:0] conn_valid_r;
  reg [7:0] state_code;
  // Packed entry words and slot bases shared by the write processes
  wire reg_write;
  wire conn_write;
  wire [REG_IDX_W+1:0] reg_base;
  wire [CONN_IDX_W:0] conn_base;
  wire [7:0] reg_sw_cap_kept;
  wire [31:0] reg_word_id_lo;
  wire [31:0] reg_word_id_hi;
  wire [31:0] reg_word_misc;
  wire [15:0] reg_word_sids;
  wire [31:0] conn_word_id_lo;
  wire [31:0] conn_word_id_hi;
  wire [23:0] conn_word_ids;

  always @* begin
    // Anything other than switch is stored as terminal so the field stays 1 or 2
    if (i_reg_state == `STATE_SWITCH) begin
      state_code = `STATE_SWITCH;
    end else begin
      state_code = `STATE_TERMINAL;
    end
  end

  // Entry words are packed once here; the read path unpacks them with the same layout
  assign reg_write = i_reg_wr & i_base_node;
  assign reg_base = {1'b0, i_reg_idx, 1'b0} + {2'b00, i_reg_idx};
  assign reg_sw_cap_kept = i_reg_sw_cap & `SWCAP_VALID_MASK;
  assign reg_word_id_lo = i_reg_node_id[31:0];
  assign reg_word_id_hi = {i_reg_local_node_id, i_reg_node_id[47:32]};
  assign reg_word_misc = {reg_sw_cap_kept,
                          i_reg_term_cap,
                          i_reg_level,
                          state_code};
  assign reg_word_sids = {i_reg_local_switch_id, i_reg_switch_id};
  // Direct connections are kept out of this list altogether
  assign conn_write = i_conn_wr & i_base_node & ~i_conn_direct;
  assign conn_base = {i_conn_idx, 1'b0};
  assign conn_word_id_lo = i_conn_node_id[31:0];
  assign conn_word_id_hi = {i_conn_node_id[47:32], i_conn_local_node_id};
  assign conn_word_ids = {i_conn_switch_id, i_conn_local_conn_id};

  always @(posedge i_clk_sys) begin
    if (reg_write) begin
      reg_mem[reg_base + `REG_W0_ID_LO] <= reg_word_id_lo;
      reg_mem[reg_base + `REG_W1_ID_HI] <= reg_word_id_hi;
      reg_mem[reg_base + `REG_W2_MISC] <= reg_word_misc;
    end
  end

  // Switch ids sit in a narrow side array; they are read back as the fourth entry word
  reg [15:0] reg_sids_mem [0:REG_ENTRIES-1];
  always @(posedge i_clk_sys) begin
    if (reg_write) begin
      reg_sids_mem[i_reg_idx] <= reg_word_sids;
    end
  end

  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      reg_valid_r <= {REG_ENTRIES{1'b0}};
      conn_valid_r <= {CONN_ENTRIES{1'b0}};
    end else begin
      if (i_reg_wr & i_base_node) begin
        reg_valid_r[i_reg_idx] <= i_reg_valid;
      end
      if (i_conn_wr & i_base_node) begin
        // Direct connections never occupy a slot here
        conn_valid_r[i_conn_idx] <= i_conn_valid & ~i_conn_direct;
      end
    end
  end

  always @(posedge i_clk_sys) begin
    if (conn_write) begin
      conn_mem[conn_base] <= conn_word_id_lo;
      conn_mem[conn_base + 1] <= conn_word_id_hi;
    end
  end

  reg [23:0] conn_extra_mem [0:CONN_ENTRIES-1];
  always @(posedge i_clk_sys) begin
    if (conn_write) begin
      conn_extra_mem[i_conn_idx] <= conn_word_ids;
    end
  end

  // Get primitive: single-cycle lookup, answered on the next edge
  reg [31:0] get_val;
  reg get_hit;
  always @* begin
    get_val = 32'h0000_0000;
    get_hit = 1'b1;
    case (i_get_id)
      `ID_FRAME_GUARD_TIME: begin
        get_val = {16'h0000, `GUARD_TIME_SYMBOLS};
      end
      `ID_BACKWARD_COMPAT_FLAG: begin
        get_val = {31'h0000_0000, bc_mode_r};
      end
      `ID_PARENT_BEACON_QUALITY: begin
        get_val = {16'h0000, parent_quality_r};
      end
      `ID_OWN_BEACON_QUALITY: begin
        get_val = {16'h0000, own_quality_r};
      end
      `ID_TX_DATA_UNIT_COUNT: begin
        get_val = counter_w[0];
      end
      `ID_RX_DATA_UNIT_COUNT: begin
        get_val = counter_w[1];
      end
      `ID_TX_CONTROL_COUNT: begin
        get_val = counter_w[2];
      end
      `ID_RX_CONTROL_COUNT: begin
        get_val = counter_w[3];
      end
      `ID_POWERLINE_ACCESS_FAIL_COUNT: begin
        get_val = counter_w[4];
      end
      `ID_POWERLINE_BUSY_BACKOFF_COUNT: begin
        get_val = counter_w[5];
      end
      `ID_RADIO_ACCESS_FAIL_COUNT: begin
        get_val = counter_w[6];
      end
      `ID_RADIO_BUSY_BACKOFF_COUNT: begin
        get_val = counter_w[7];
      end
      default: begin
        get_hit = 1'b0;
      end
    endcase
  end

  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_get_ack <= 1'b0;
      o_get_ok <= 1'b0;
      o_get_data <= 32'h0000_0000;
    end else begin
      o_get_ack <= i_get_req;
      // Ok and data hold until the next request, so a slow reader still sees them
      if (i_get_req) begin
        o_get_ok <= get_hit;
        o_get_data <= get_hit ? get_val : 32'h0000_0000;
      end
    end
  end

  // List-get primitive: one word of one entry per request
  reg [31:0] reg_list_val;
  reg reg_list_hit;
  reg reg_list_valid;
  integer reg_rd_base;
  always @* begin
    reg_list_val = 32'h0000_0000;
    reg_list_hit = 1'b0;
    reg_list_valid = 1'b0;
    reg_rd_base = 0;
    // Lists exist only on a base node; elsewhere the identifier is unknown
    if (i_base_node && i_list_id == `ID_REGISTERED_NODE_LIST && i_list_entry < REG_ENTRIES) begin
      reg_list_hit = 1'b1;
      reg_list_valid = reg_valid_r[i_list_entry[REG_IDX_W-1:0]];
      reg_rd_base = i_list_entry[REG_IDX_W-1:0] * `REG_WORDS;
      case (i_list_word)
        2'h0: reg_list_val = reg_mem[reg_rd_base + `REG_W0_ID_LO];
        2'h1: reg_list_val = reg_mem[reg_rd_base + `REG_W1_ID_HI];
        2'h2: reg_list_val = reg_mem[reg_rd_base + `REG_W2_MISC];
        default: reg_list_val = {16'h0000, reg_sids_mem[i_list_entry[REG_IDX_W-1:0]]};
      endcase
    end
  end

  // The connection entry has three words, so a fourth word index is refused
  reg [31:0] conn_list_val;
  reg conn_list_hit;
  reg conn_list_valid;
  integer conn_rd_base;
  always @* begin
    conn_list_val = 32'h0000_0000;
    conn_list_hit = 1'b0;
    conn_list_valid = 1'b0;
    conn_rd_base = 0;
    if (i_base_node && i_list_id == `ID_ACTIVE_CONNECTION_LIST &&
        i_list_entry < CONN_ENTRIES && i_list_word <= 2'h2) begin
      conn_list_hit = 1'b1;
      conn_list_valid = conn_valid_r[i_list_entry[CONN_IDX_W-1:0]];
      conn_rd_base = i_list_entry[CONN_IDX_W-1:0] * `CONN_WORDS;
      case (i_list_word)
        2'h0: conn_list_val = conn_mem[conn_rd_base];
        2'h1: conn_list_val = conn_mem[conn_rd_base + 1];
        default: conn_list_val = {8'h00, conn_extra_mem[i_list_entry[CONN_IDX_W-1:0]]};
      endcase
    end
  end

  // At most one lookup hits, since the two list identifiers differ
  wire [31:0] list_val;
  wire list_hit;
  wire list_valid;
  assign list_hit = reg_list_hit | conn_list_hit;
  assign list_valid = reg_list_valid | conn_list_valid;
  assign list_val = reg_list_val | conn_list_val;

  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_list_ack <= 1'b0;
      o_list_ok <= 1'b0;
      o_list_entry_valid <= 1'b0;
      o_list_data <= 32'h0000_0000;
    end else begin
      o_list_ack <= i_list_req;
      if (i_list_req) begin
        o_list_ok <= list_hit;
        o_list_entry_valid <= list_valid;
        // Invalid slots read as zero so stale contents never leak out
        o_list_data <= (list_hit & list_valid) ? list_val : 32'h0000_0000;
      end
    end
  end

endmodule // mac_statistics_attribute_bank

// file: stats_monitor.sv
// Purpose: Port-level checks of the MAC attribute bank
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to every instance of the bank
`timescale 1ns/1ns
`include "mac_stats_map.vh"
module stats_monitor (
  input wire i_clk_sys,
  input wire i_reset,
  input wire i_base_node,
  input wire i_tx_data_ok,
  input wire i_get_req,
  input wire [15:0] i_get_id,
  input wire o_get_ack,
  input wire o_get_ok,
  input wire [31:0] o_get_data,
  input wire i_list_req,
  input wire [15:0] i_list_id,
  input wire [1:0] i_list_word,
  input wire o_list_ack,
  input wire o_list_ok,
  input wire [31:0] o_list_data
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  sequence get_tx_s;
    i_get_req && i_get_id == `ID_TX_DATA_UNIT_COUNT;
  endsequence
  sequence misc_word_s;
    i_list_req && i_list_id == `ID_REGISTERED_NODE_LIST && i_list_word == 2'h2;
  endsequence
  a_get_ack_pulse: assert property (i_get_req |=> o_get_ack) else $error("get ack missing");
  a_no_stray_ack: assert property (!i_get_req |=> !o_get_ack) else $error("get ack without request");
  a_guard_one_symbol: assert property (i_get_req && i_get_id == `ID_FRAME_GUARD_TIME |=>
    o_get_ok && o_get_data == 32'h0000_0001) else $error("guard time not one symbol");
  a_compat_flag_bit: assert property (i_get_req && i_get_id == `ID_BACKWARD_COMPAT_FLAG |=>
    o_get_ok && o_get_data[31:1] == 31'h0) else $error("compat flag beyond one bit");
  a_unknown_id_refused: assert property (i_get_req && i_get_id == 16'h0031 |=>
    !o_get_ok && o_get_data == 32'h0) else $error("unknown id answered");
  // Back-to-back reads must differ by exactly the event seen with the first one
  a_tx_count_step: assert property (get_tx_s ##1 get_tx_s |=>
    o_get_data == $past(o_get_data) + {31'h0, $past(i_tx_data_ok, 2)}) else $error("tx count step wrong");
  a_list_ack_pulse: assert property (i_list_req |=> o_list_ack) else $error("list ack missing");
  a_nonbase_refused: assert property (i_list_req && !i_base_node |=>
    !o_list_ok && o_list_data == 32'h0) else $error("list served on non-base node");
  a_state_code: assert property (misc_word_s |=> o_list_data[7:0] == 8'h01 || o_list_data[7:0] == 8'h02 ||
    o_list_data == 32'h0) else $error("bad state code");
  a_swcap_reserved: assert property (misc_word_s |=>
    (o_list_data[31:24] & 8'hF6) == 8'h00) else $error("reserved switching bit set");
  c_back_to_back: cover property (get_tx_s ##1 get_tx_s);
  c_list_ok: cover property (i_list_req ##1 o_list_ok);
  c_refused: cover property (i_get_req ##1 !o_get_ok);
endmodule // stats_monitor

bind mac_statistics_attribute_bank stats_monitor u_mon (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
  .i_base_node(i_base_node), .i_tx_data_ok(i_tx_data_ok), .i_get_req(i_get_req), .i_get_id(i_get_id),
  .o_get_ack(o_get_ack), .o_get_ok(o_get_ok), .o_get_data(o_get_data), .i_list_req(i_list_req),
  .i_list_id(i_list_id), .i_list_word(i_list_word), .o_list_ack(o_list_ack), .o_list_ok(o_list_ok),
  .o_list_data(o_list_data));

// file: tb_top.sv
// Purpose: Self-checking bench for the MAC attribute bank
// Assumes: Get and list-get answer one cycle after the request
// Notes: Table rows cover every get identifier; lists and reset follow by hand
`timescale 1ns/1ns
`include "mac_stats_map.vh"
module tb_top;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic [11:0] ev = 12'h000;
  logic [6:0] c = 7'h4A;
  logic [3:0] ix = 4'h0;
  logic [15:0] bq = 16'hA5C3;
  logic [127:0] rv = {16'h0, 8'hFF, 8'hA5, 8'h03, 8'h07, 8'h06, 8'h02, 16'h0123, 48'hBA98_7654_3210};
  logic gq = 1'b0;
  logic [15:0] gid = 16'h0000;
  logic lq = 1'b0;
  logic [15:0] lid = 16'h0000;
  logic [7:0] le = 8'h00;
  logic [1:0] lw = 2'h0;
  wire ga, gok, la, lok, lv;
  wire [31:0] gd, ld;
  int error_cnt = 0;
  int n_compared = 0;
  logic [9:0] cm [0:7] = '{10'h001, 10'h006, 10'h008, 10'h030, 10'h040, 10'h080, 10'h100, 10'h200};
  logic [48:0] rows [0:13] = '{{`ID_FRAME_GUARD_TIME, 1'b1, 32'h1}, {`ID_BACKWARD_COMPAT_FLAG, 1'b1, 32'h1},
    {`ID_PARENT_BEACON_QUALITY, 1'b1, 32'hA5C3}, {`ID_OWN_BEACON_QUALITY, 1'b1, 32'h5A3C},
    {16'h0040, 1'b1, 32'h1}, {16'h0041, 1'b1, 32'h2}, {16'h0042, 1'b1, 32'h3}, {16'h0043, 1'b1, 32'h4},
    {16'h0044, 1'b1, 32'h5}, {16'h0045, 1'b1, 32'h6}, {16'h0046, 1'b1, 32'h7}, {16'h0047, 1'b1, 32'h8},
    {16'h0031, 1'b0, 32'h0}, {16'h0048, 1'b0, 32'h0}};
  logic [31:0] rw [0:3] = '{32'h7654_3210, 32'h0123_BA98, 32'h09A5_0302, 32'h0000_0607};
  logic [31:0] cw [0:2] = '{32'h7654_3210, 32'hBA98_0123, 32'h0007_7654};

  always #20 i_clk_sys = ~i_clk_sys;

  mac_statistics_attribute_bank i_dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_base_node(c[5]),
    .i_backward_compat_mode(c[6]), .i_parent_beacon_quality(bq), .i_parent_beacon_valid(ev[10]),
    .i_own_beacon_quality(~bq), .i_own_beacon_valid(ev[11]), .i_tx_data_ok(ev[0]), .i_rx_data_ok(ev[1]),
    .i_rx_data_for_me(ev[2]), .i_tx_ctrl_ok(ev[3]), .i_rx_ctrl_ok(ev[4]), .i_rx_ctrl_for_me(ev[5]),
    .i_powerline_access_fail(ev[6]), .i_powerline_busy_backoff(ev[7]), .i_radio_access_fail(ev[8]),
    .i_radio_busy_backoff(ev[9]), .i_reg_wr(c[0]), .i_reg_idx(ix), .i_reg_valid(c[1]),
    .i_reg_node_id(rv[47:0]), .i_reg_local_node_id(rv[63:48]), .i_reg_state(rv[71:64]),
    .i_reg_local_switch_id(rv[79:72]), .i_reg_switch_id(rv[87:80]), .i_reg_level(rv[95:88]),
    .i_reg_term_cap(rv[103:96]), .i_reg_sw_cap(rv[111:104]), .i_conn_wr(c[2]), .i_conn_idx(ix),
    .i_conn_valid(c[3]), .i_conn_direct(c[4]), .i_conn_switch_id(rv[87:80]),
    .i_conn_local_node_id(rv[63:48]), .i_conn_local_conn_id(rv[31:16]), .i_conn_node_id(rv[47:0]),
    .i_get_req(gq), .i_get_id(gid), .o_get_ack(ga), .o_get_ok(gok), .o_get_data(gd), .i_list_req(lq),
    .i_list_id(lid), .i_list_entry(le), .i_list_word(lw), .o_list_ack(la), .o_list_ok(lok),
    .o_list_entry_valid(lv), .o_list_data(ld));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic ping(input logic [11:0] m, input int n);
    repeat (n) @(posedge i_clk_sys) ev <= m;
    @(posedge i_clk_sys) ev <= 12'h000;
  endtask

  task automatic wr(input logic [6:0] m);
    @(posedge i_clk_sys) c <= c | m;
    @(posedge i_clk_sys) c <= c & ~m;
  endtask

  task automatic get(input logic [15:0] id);
    @(posedge i_clk_sys) gid <= id;
    gq <= 1'b1;
    @(posedge i_clk_sys) gq <= 1'b0;
    #1;
  endtask

  task automatic lget(input logic [15:0] id, input logic [7:0] e, input logic [1:0] w, input logic [1:0] f,
                      input logic [31:0] d);
    @(posedge i_clk_sys) lid <= id;
    le <= e;
    lw <= w;
    lq <= 1'b1;
    @(posedge i_clk_sys) lq <= 1'b0;
    #1 chk("list flags", {29'h0, 1'b1, f}, {29'h0, la, lok, lv});
    chk("list data", d, ld);
  endtask

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    ping(12'hC00, 1);
    // Quality sources move after capture; the attributes must not follow them
    bq <= 16'h1234;
    for (int k = 0; k < 8; k++) ping({2'b00, cm[k]}, k + 1);
    ping(12'h002, 2);
    ping(12'h004, 1);
    ping(12'h010, 2);
    ping(12'h020, 1);
    for (int r = 0; r < 14; r++) begin
      get(rows[r][48:33]);
      chk("get flags", {30'h0, 1'b1, rows[r][32]}, {30'h0, ga, gok});
      chk("get data", rows[r][31:0], gd);
    end
    $display("table test done");
    @(posedge i_clk_sys) gid <= 16'h0040;
    gq <= 1'b1;
    ev <= 12'h001;
    @(posedge i_clk_sys) ev <= 12'h000;
    #1 chk("pre-increment read", 32'h1, gd);
    @(posedge i_clk_sys) gq <= 1'b0;
    #1 chk("post-increment read", 32'h2, gd);
    $display("same-cycle test done");
    wr(7'h01);
    lget(`ID_REGISTERED_NODE_LIST, 8'h00, 2'h0, 2'b00, 32'h0);
    @(posedge i_clk_sys) c[5] <= 1'b1;
    lget(`ID_REGISTERED_NODE_LIST, 8'h00, 2'h0, 2'b10, 32'h0);
    ix <= 4'h2;
    wr(7'h01);
    for (int w = 0; w < 4; w++) lget(`ID_REGISTERED_NODE_LIST, 8'h02, w[1:0], 2'b11, rw[w]);
    rv[71:64] <= 8'h05;
    ix <= 4'h3;
    wr(7'h01);
    lget(`ID_REGISTERED_NODE_LIST, 8'h03, 2'h2, 2'b11, 32'h09A5_0301);
    lget(`ID_REGISTERED_NODE_LIST, 8'h10, 2'h0, 2'b00, 32'h0);
    lget(16'h0052, 8'h00, 2'h0, 2'b00, 32'h0);
    ix <= 4'h1;
    c[4] <= 1'b1;
    wr(7'h04);
    lget(`ID_ACTIVE_CONNECTION_LIST, 8'h01, 2'h0, 2'b10, 32'h0);
    @(posedge i_clk_sys) c[4] <= 1'b0;
    wr(7'h04);
    for (int w = 0; w < 3; w++) lget(`ID_ACTIVE_CONNECTION_LIST, 8'h01, w[1:0], 2'b11, cw[w]);
    lget(`ID_ACTIVE_CONNECTION_LIST, 8'h01, 2'h3, 2'b00, 32'h0);
    $display("list test done");
    c[6] <= 1'b0;
    @(posedge i_clk_sys) i_reset <= 1'b1;
    @(posedge i_clk_sys) i_reset <= 1'b0;
    get(16'h0040);
    chk("count after reset", 32'h0, gd);
    get(`ID_BACKWARD_COMPAT_FLAG);
    chk("flag after reset", 32'h0, gd);
    get(`ID_PARENT_BEACON_QUALITY);
    chk("quality after reset", 32'h0, gd);
    lget(`ID_REGISTERED_NODE_LIST, 8'h02, 2'h0, 2'b10, 32'h0);
    $display("reset test done");
    results;
  end

  // The whole sequence needs under two hundred cycles; this margin only cuts a hang
  initial begin
    repeat (3000) @(posedge i_clk_sys);
    error_cnt++;
    results;
  end
endmodule // tb_top
